// ===== rtop_params.sv
// parameter bank top: registers, motor select and restart sequencer
`timescale 1ns/100ps
module rtop_params #(
  parameter int TICK_CYCLES = rtop_pkg::TICK_CYCLES
) (
  input  wire logic                          i_clk,
  input  wire logic                          i_resetn,
  input  wire rtop_pkg::rtop_req_t           i_req,
  output logic [rtop_pkg::DATA_W-1:0]        o_rdata,
  output logic                               o_ack,
  output logic                               o_err,
  input  wire logic                          i_motor2_sel,
  input  wire logic                          i_undervoltage,
  input  wire logic                          i_trip_clear,
  output rtop_pkg::rtop_cfg_t                o_cfg,
  output rtop_pkg::rtop_evt_t                o_evt,
  output logic                               o_run_enable,
  output logic                               o_alarm,
  output logic [4:0]                         o_restart_count
);

  logic [rtop_pkg::NREG-1:0][15:0] regs;
  logic                            tick;

  rtop_regfile u_regs (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_req    (i_req),
    .o_rdata  (o_rdata),
    .o_ack    (o_ack),
    .o_err    (o_err),
    .o_regs   (regs)
  );

  rtop_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .o_tick   (tick)
  );

  // selected-motor settings for the drive control logic
  rtop_pkg::rtop_cfg_t cfg;
  rtop_pkg::rtop_cfg_t next_cfg;

  always_comb begin
    next_cfg.restart_mode = rtop_pkg::rtop_restart_t'(regs[0][1:0]);
    next_cfg.alarm_enable = regs[3][0];
    next_cfg.unlimited    = regs[4][0];
    next_cfg.pullin_sel   = rtop_pkg::rtop_pullin_t'(regs[9][1:0]);
    if (i_motor2_sel) begin
      next_cfg.thermal_level = regs[10];
      next_cfg.thermal_curve = rtop_pkg::rtop_curve_t'(regs[11][1:0]);
      next_cfg.ol_mode       = rtop_pkg::rtop_olmode_t'(regs[12][1:0]);
      next_cfg.ol_level      = regs[13];
    end else begin
      next_cfg.thermal_level = regs[5];
      next_cfg.thermal_curve = rtop_pkg::rtop_curve_t'(regs[6][1:0]);
      next_cfg.ol_mode       = rtop_pkg::rtop_olmode_t'(regs[7][1:0]);
      next_cfg.ol_level      = regs[8];
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cfg <= '0;
    end else begin
      cfg <= next_cfg;
    end
  end

  assign o_cfg = cfg;

  // restart sequencer
  typedef enum logic [1:0] {
    RTOP_ST_RUN     = 2'b00,
    RTOP_ST_OUTAGE  = 2'b01,
    RTOP_ST_WAIT    = 2'b11,
    RTOP_ST_TRIPPED = 2'b10
  } rtop_state_t;

  rtop_state_t         state;
  rtop_state_t         next_state;
  logic [15:0]         timer;
  logic [15:0]         next_timer;
  logic [4:0]          count;
  logic [4:0]          next_count;
  rtop_pkg::rtop_evt_t evt;
  rtop_pkg::rtop_evt_t next_evt;
  logic                alarm;
  logic                next_alarm;

  always_comb begin
    next_state = state;
    next_timer = timer;
    next_count = count;
    next_alarm = alarm;
    next_evt   = '0;
    unique case (state)
      RTOP_ST_RUN: begin
        if (i_undervoltage) begin
          next_state = RTOP_ST_OUTAGE;
          next_timer = 16'h0000;
        end
      end
      RTOP_ST_OUTAGE: begin
        if (tick) begin
          next_timer = timer + 16'h0001;
        end
        if (i_undervoltage && tick && timer >= regs[1]) begin
          next_state    = RTOP_ST_TRIPPED;
          next_evt.trip = 1'b1;
          next_alarm    = cfg.alarm_enable;
        end else if (!i_undervoltage) begin
          if (cfg.restart_mode == rtop_pkg::RTOP_RS_ALARM ||
              (!cfg.unlimited &&
               count >= 5'(rtop_pkg::RESTART_LIMIT))) begin
            next_state    = RTOP_ST_TRIPPED;
            next_evt.trip = 1'b1;
            next_alarm    = cfg.alarm_enable;
          end else begin
            next_state = RTOP_ST_WAIT;
            next_timer = 16'h0000;
          end
        end
      end
      RTOP_ST_WAIT: begin
        if (i_undervoltage) begin
          next_state = RTOP_ST_OUTAGE;
          next_timer = 16'h0000;
        end else begin
          if (tick) begin
            next_timer = timer + 16'h0001;
          end
          // full retry delay elapsed: never restart early on tick phase
          if (tick && timer >= regs[2]) begin
            next_state       = RTOP_ST_RUN;
            next_evt.restart = 1'b1;
            next_count       = count + 5'h01;
            if (cfg.restart_mode == rtop_pkg::RTOP_RS_MATCH_STOP) begin
              next_evt.decel_stop = 1'b1;
              next_evt.trip       = 1'b1;
            end
          end
        end
      end
      RTOP_ST_TRIPPED: begin
        if (i_trip_clear) begin
          next_state = RTOP_ST_RUN;
          next_count = 5'h00;
          next_alarm = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state <= RTOP_ST_RUN;
      timer <= 16'h0000;
      count <= 5'h00;
      evt   <= '0;
      alarm <= 1'b0;
    end else begin
      state <= next_state;
      timer <= next_timer;
      count <= next_count;
      evt   <= next_evt;
      alarm <= next_alarm;
    end
  end

  assign o_evt           = evt;
  assign o_alarm         = alarm;
  assign o_restart_count = count;
  assign o_run_enable    = (state == RTOP_ST_RUN);

endmodule

// ===== rtop_pkg.sv
// package: register map, encodings, ranges and carriers for the parameter bank
// How it works
// - restart mode 0 alarm only, 1 zero start, 2 match resume, 3 match-stop-trip.
// - under-voltage longer than allowed outage time trips, restart mode notwithstanding.
// - after under-voltage clears, wait retry delay before driving motor again.
// - power failure trip alarm disabled at 0, enabled at 1; the code raises no alarm on the mode 3 trip after restart.
// - restart count 0 limits restarts to 16; 1 allows unlimited restarts.
// - pull-in start frequency 0 previous shutoff, 1 maximum, 2 set frequency.
// - thermal level in 0.01 percent, accepting 2000 to 10000.
// - thermal curve 0 reduced torque one, 1 constant, 2 reduced two.
// - overload mode 0 off, 1 accel and constant speed, 2 constant only.
// - overload level in 0.01 percent, accepting 2000 to 15000.
package rtop_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int NREG   = 14;

  // register offsets, index order matches the storage array
  localparam logic [15:0] OFF_RESTART_MODE  = 16'h10a5;
  localparam logic [15:0] OFF_UV_ALLOW      = 16'h10a6;
  localparam logic [15:0] OFF_RETRY_WAIT    = 16'h10a7;
  localparam logic [15:0] OFF_PF_ALARM_EN   = 16'h10a8;
  localparam logic [15:0] OFF_RESTART_COUNT = 16'h10a9;
  localparam logic [15:0] OFF_THERM_LVL     = 16'h10ad;
  localparam logic [15:0] OFF_THERM_CURVE   = 16'h10ae;
  localparam logic [15:0] OFF_OL_MODE       = 16'h10b5;
  localparam logic [15:0] OFF_OL_LVL        = 16'h10b6;
  localparam logic [15:0] OFF_PULLIN_SEL    = 16'h1170;
  localparam logic [15:0] OFF_THERM_LVL2    = 16'h1527;
  localparam logic [15:0] OFF_THERM_CURVE2  = 16'h1528;
  localparam logic [15:0] OFF_OL_MODE2      = 16'h1529;
  localparam logic [15:0] OFF_OL_LVL2       = 16'h152a;

  localparam logic [15:0] REG_OFF [NREG] = '{
    OFF_RESTART_MODE, OFF_UV_ALLOW, OFF_RETRY_WAIT, OFF_PF_ALARM_EN,
    OFF_RESTART_COUNT, OFF_THERM_LVL, OFF_THERM_CURVE, OFF_OL_MODE,
    OFF_OL_LVL, OFF_PULLIN_SEL, OFF_THERM_LVL2, OFF_THERM_CURVE2,
    OFF_OL_MODE2, OFF_OL_LVL2};

  // permitted ranges, minimum and maximum per register
  localparam logic [15:0] REG_MIN [NREG] = '{
    16'h0000, 16'h0003, 16'h0003, 16'h0000, 16'h0000, 16'h07d0, 16'h0000,
    16'h0000, 16'h07d0, 16'h0000, 16'h07d0, 16'h0000, 16'h0000, 16'h07d0};
  localparam logic [15:0] REG_MAX [NREG] = '{
    16'h0003, 16'h00fa, 16'h03e8, 16'h0001, 16'h0001, 16'h2710, 16'h0002,
    16'h0002, 16'h3a98, 16'h0002, 16'h2710, 16'h0002, 16'h0002, 16'h3a98};
  // reset values: restart mode, flags and pull-in at 0, times at 10, curves and overload modes at 1, thermal levels at maximum, overload levels 12000
  localparam logic [15:0] REG_RST [NREG] = '{
    16'h0000, 16'h000a, 16'h000a, 16'h0000, 16'h0000, 16'h2710, 16'h0001,
    16'h0001, 16'h2ee0, 16'h0000, 16'h2710, 16'h0001, 16'h0001, 16'h2ee0};

  // restart, timing and counting constants
  localparam int    CLK_HZ          = 200_000_000;
  localparam int    TENTH_SEC_MS    = 100;
  localparam int    TICK_CYCLES     = CLK_HZ / 1000 * TENTH_SEC_MS;
  localparam int    RESTART_LIMIT   = 16;

  typedef enum logic [1:0] {
    RTOP_RS_ALARM = 2'h0, RTOP_RS_ZERO = 2'h1,
    RTOP_RS_MATCH = 2'h2, RTOP_RS_MATCH_STOP = 2'h3} rtop_restart_t;
  typedef enum logic [1:0] {
    RTOP_PF_PREV = 2'h0, RTOP_PF_MAX = 2'h1, RTOP_PF_SET = 2'h2} rtop_pullin_t;
  typedef enum logic [1:0] {
    RTOP_TC_RED1 = 2'h0, RTOP_TC_CONST = 2'h1, RTOP_TC_RED2 = 2'h2} rtop_curve_t;
  typedef enum logic [1:0] {
    RTOP_OL_OFF = 2'h0, RTOP_OL_ACC_CONST = 2'h1,
    RTOP_OL_CONST = 2'h2} rtop_olmode_t;

  // register bus request
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } rtop_req_t;

  // decoded settings for the active motor, to the drive control logic
  typedef struct packed {
    rtop_restart_t restart_mode;
    logic          alarm_enable;
    logic          unlimited;
    rtop_pullin_t  pullin_sel;
    logic [15:0]   thermal_level;
    rtop_curve_t   thermal_curve;
    rtop_olmode_t  ol_mode;
    logic [15:0]   ol_level;
  } rtop_cfg_t;

  // restart sequencer events
  typedef struct packed {
    logic trip;
    logic restart;
    logic decel_stop;
  } rtop_evt_t;

endpackage

// ===== rtop_regfile.sv
// register storage with range checking on each write
`timescale 1ns/100ps
module rtop_regfile (
  input  wire logic                          i_clk,
  input  wire logic                          i_resetn,
  input  wire rtop_pkg::rtop_req_t           i_req,
  output logic [rtop_pkg::DATA_W-1:0]        o_rdata,
  output logic                               o_ack,
  output logic                               o_err,
  output logic [rtop_pkg::NREG-1:0][15:0]    o_regs
);

  logic [rtop_pkg::NREG-1:0][15:0] regs;
  logic [rtop_pkg::NREG-1:0][15:0] next_regs;
  logic [15:0]                     rdata;
  logic [15:0]                     next_rdata;
  logic                            ack;
  logic                            next_ack;
  logic                            err;
  logic                            next_err;
  logic [rtop_pkg::NREG-1:0]       hit;

  // address decode, one hit line per register
  genvar g;
  generate
    for (g = 0; g < rtop_pkg::NREG; g++) begin : g_dec
      assign hit[g] = (i_req.addr == rtop_pkg::REG_OFF[g]);
    end
  endgenerate

  // write with range check, read mux, answer flags
  always_comb begin
    next_regs  = regs;
    next_rdata = rdata;
    next_ack   = 1'b0;
    next_err   = 1'b0;
    if (i_req.wr || i_req.rd) begin
      next_ack = 1'b1;
      next_err = ~|hit;
    end
    for (int i = 0; i < rtop_pkg::NREG; i++) begin
      if (hit[i] && i_req.rd) begin
        next_rdata = regs[i];
      end
      if (hit[i] && i_req.wr) begin
        if (i_req.wdata >= rtop_pkg::REG_MIN[i] &&
            i_req.wdata <= rtop_pkg::REG_MAX[i]) begin
          next_regs[i] = i_req.wdata;
        end else begin
          next_err = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      for (int i = 0; i < rtop_pkg::NREG; i++) begin
        regs[i] <= rtop_pkg::REG_RST[i];
      end
      rdata <= 16'h0000;
      ack   <= 1'b0;
      err   <= 1'b0;
    end else begin
      regs  <= next_regs;
      rdata <= next_rdata;
      ack   <= next_ack;
      err   <= next_err;
    end
  end

  assign o_regs  = regs;
  assign o_rdata = rdata;
  assign o_ack   = ack;
  assign o_err   = err;

endmodule

// ===== rtop_tick.sv
// tenth-of-a-second tick generator
`timescale 1ns/100ps
module rtop_tick #(
  parameter int TICK_CYCLES = rtop_pkg::TICK_CYCLES
) (
  input  wire logic i_clk,
  input  wire logic i_resetn,
  output logic      o_tick
);

  logic [31:0] cnt;
  logic [31:0] next_cnt;

  // free running divider, pulse at wrap
  always_comb begin
    if (cnt >= 32'(TICK_CYCLES - 1)) begin
      next_cnt = 32'h0000_0000;
    end else begin
      next_cnt = cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt <= 32'h0000_0000;
    end else begin
      cnt <= next_cnt;
    end
  end

  assign o_tick = (cnt >= 32'(TICK_CYCLES - 1));

endmodule

// ===== rtop_params_sva.sv
// checker: answers, range refusals and sequencer events
`timescale 1ns/100ps
module rtop_params_sva (
  input wire logic                i_clk,
  input wire logic                i_resetn,
  input wire rtop_pkg::rtop_req_t i_req,
  input wire logic                o_ack,
  input wire logic                o_err,
  input wire rtop_pkg::rtop_cfg_t o_cfg,
  input wire rtop_pkg::rtop_evt_t o_evt,
  input wire logic                o_alarm,
  input wire logic [4:0]          o_restart_count
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  // a refused write answers with the error flag
  err_with_ack_a: assert property (o_err |-> o_ack)
    else $error("error flag without answer");
  mode_refuse_a: assert property (i_req.wr
    && i_req.addr == rtop_pkg::OFF_RESTART_MODE && i_req.wdata > 16'h3
    |=> o_err) else $error("bad restart mode taken");
  allow_refuse_a: assert property (i_req.wr
    && i_req.addr == rtop_pkg::OFF_UV_ALLOW
    && (i_req.wdata < 16'h3 || i_req.wdata > 16'hfa) |=> o_err)
    else $error("bad outage time taken");
  retry_refuse_a: assert property (i_req.wr
    && i_req.addr == rtop_pkg::OFF_RETRY_WAIT
    && (i_req.wdata < 16'h3 || i_req.wdata > 16'h3e8) |=> o_err)
    else $error("bad retry wait taken");
  therm_refuse_a: assert property (i_req.wr
    && i_req.addr == rtop_pkg::OFF_THERM_LVL2
    && (i_req.wdata < 16'h7d0 || i_req.wdata > 16'h2710) |=> o_err)
    else $error("bad thermal level taken");
  ol_refuse_a: assert property (i_req.wr
    && i_req.addr == rtop_pkg::OFF_OL_LVL && i_req.wdata > 16'h3a98
    |=> o_err) else $error("bad overload level taken");
  // a legal mode write reaches the decoded settings two cycles on
  mode_load_a: assert property (i_req.wr
    && i_req.addr == rtop_pkg::OFF_RESTART_MODE && i_req.wdata < 16'h4
    |=> ##1 o_cfg.restart_mode == $past(i_req.wdata[1:0], 2))
    else $error("restart mode not applied");
  alarm_gate_a: assert property ($rose(o_alarm)
    |-> o_cfg.alarm_enable) else $error("alarm while disabled");
  count_cap_a: assert property (!o_cfg.unlimited
    |-> o_restart_count <= 5'd16) else $error("restart count past limit");
  trip_pulse_a: assert property (o_evt.trip
    |=> !o_evt.trip) else $error("trip pulse too long");
endmodule

// ===== rtop_master.sv
// network master model driving the register request port
`timescale 1ns/100ps
module rtop_master (
  input  wire logic           i_clk,
  output rtop_pkg::rtop_req_t o_req
);
  initial o_req = '0;
  // one request per cycle, launched on the falling edge
  task automatic access(input logic w, r, input logic [15:0] a, d);
    @(negedge i_clk);
    o_req <= '{w, r, a, d};
  endtask
  // released bus shows the inverse of the last address and data
  task automatic idle();
    @(negedge i_clk);
    o_req <= '{1'b0, 1'b0, ~o_req.addr, ~o_req.wdata};
  endtask
endmodule

// ===== rtop_params_test.sv
// testbench for the parameter bank and restart sequencer
`timescale 1ns/100ps
module rtop_params_test;
  logic clk = 0, resetn = 0, m2 = 0, uv = 0, clr = 0;
  logic [15:0] rdata, shadow [14];
  logic ack, err, run, alarm;
  logic [4:0] cnt;
  logic [17:0] n, notes [$];
  rtop_pkg::rtop_req_t req;
  rtop_pkg::rtop_cfg_t cfg;
  rtop_pkg::rtop_evt_t evt;
  int err_total = 0, comparisons = 0, cyc = 0, trips = 0, rsts = 0;
  int t_trip = 0, t_rst = 0, t0 = 0, stops = 0;
  // 200 MHz clock
  always #2.5 clk = ~clk;
  rtop_params #(.TICK_CYCLES(10)) u_rtop_params (.i_clk(clk),
    .i_resetn(resetn), .i_req(req), .o_rdata(rdata), .o_ack(ack),
    .o_err(err), .i_motor2_sel(m2), .i_undervoltage(uv),
    .i_trip_clear(clr), .o_cfg(cfg), .o_evt(evt), .o_run_enable(run),
    .o_alarm(alarm), .o_restart_count(cnt));
  rtop_master u_rtop_master (.i_clk(clk), .o_req(req));
  task automatic check(input logic ok, input string m);
    comparisons++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  function automatic int idx(input logic [15:0] a);
    for (int k = 0; k < 14; k++) if (rtop_pkg::REG_OFF[k] === a) return k;
    return -1;
  endfunction
  // write: note the refusal expected from the legal range
  task automatic wr(input logic [15:0] a, d);
    int i;
    logic ok;
    i = idx(a);
    ok = i >= 0;
    if (ok) ok = d >= rtop_pkg::REG_MIN[i] && d <= rtop_pkg::REG_MAX[i];
    if (ok) shadow[i] = d;
    notes.push_back({1'b0, !ok, 16'h0});
    u_rtop_master.access(1'b1, 1'b0, a, d);
  endtask
  task automatic rd(input logic [15:0] a);
    int i;
    i = idx(a);
    notes.push_back({i >= 0, i < 0, i >= 0 ? shadow[i] : 16'h0});
    u_rtop_master.access(1'b0, 1'b1, a, 16'h0);
  endtask
  // short outage of twelve cycles, then let the sequencer settle
  task automatic blip(input int settle);
    uv = 1;
    repeat (12) @(negedge clk);
    uv = 0;
    t0 = cyc;
    repeat (settle) @(negedge clk);
  endtask
  // answer watcher, events and hang limit
  always @(posedge clk) begin
    cyc++;
    if (evt.decel_stop === 1'b1) stops++;
    if (evt.trip === 1'b1) begin
      trips++;
      t_trip = cyc;
    end
    if (evt.restart === 1'b1) begin
      rsts++;
      t_rst = cyc;
    end
    if (ack === 1'b1) begin
      n = notes.pop_front();
      check(err === n[16] && (!n[17] || rdata === n[15:0]), "answer");
    end
    if (cyc > 5000) begin
      err_total++;
      print_verdict();
    end
  end
  // main sequence
  initial begin
    void'($urandom(32'h90da9945));
    foreach (shadow[k]) shadow[k] = rtop_pkg::REG_RST[k];
    repeat (5) @(negedge clk);
    resetn = 1;
    for (int k = 0; k < 14; k++) rd(rtop_pkg::REG_OFF[k]);
    for (int k = 0; k < 14; k++) begin
      wr(rtop_pkg::REG_OFF[k], rtop_pkg::REG_MAX[k] + 16'h1);
      if (rtop_pkg::REG_MIN[k] > 0)
        wr(rtop_pkg::REG_OFF[k], rtop_pkg::REG_MIN[k] - 16'h1);
      if (rtop_pkg::REG_MAX[k] < 4)
        for (int v = 0; v <= rtop_pkg::REG_MAX[k]; v++)
          wr(rtop_pkg::REG_OFF[k], 16'(v));
      wr(rtop_pkg::REG_OFF[k], 16'(rtop_pkg::REG_MIN[k] + $urandom % (
        rtop_pkg::REG_MAX[k] - rtop_pkg::REG_MIN[k] + 1)));
    end
    wr(16'h10aa, 16'h1);
    rd(16'h10aa);
    for (int k = 0; k < 14; k++) rd(rtop_pkg::REG_OFF[k]);
    m2 = 1;
    u_rtop_master.idle();
    repeat (3) @(negedge clk);
    check(cfg.thermal_level === shadow[10]
      && cfg.thermal_curve === shadow[11][1:0]
      && cfg.ol_mode === shadow[12][1:0]
      && cfg.ol_level === shadow[13], "motor two");
    m2 = 0;
    wr(rtop_pkg::OFF_RESTART_MODE, 16'h1);
    wr(rtop_pkg::OFF_UV_ALLOW, 16'h3);
    wr(rtop_pkg::OFF_RETRY_WAIT, 16'h3);
    wr(rtop_pkg::OFF_PF_ALARM_EN, 16'h1);
    wr(rtop_pkg::OFF_RESTART_COUNT, 16'h0);
    u_rtop_master.idle();
    repeat (3) @(negedge clk);
    // first-motor settings reach the decoded outputs
    check(cfg.restart_mode === rtop_pkg::RTOP_RS_ZERO
      && cfg.alarm_enable === 1'b1 && cfg.unlimited === 1'b0
      && cfg.pullin_sel === shadow[9][1:0]
      && cfg.thermal_level === shadow[5]
      && cfg.thermal_curve === shadow[6][1:0]
      && cfg.ol_mode === shadow[7][1:0]
      && cfg.ol_level === shadow[8], "motor one");
    // a long outage trips within three to four ticks
    trips = 0;
    t0 = cyc;
    uv = 1;
    repeat (60) @(negedge clk);
    check(trips == 1 && t_trip - t0 > 30 && t_trip - t0 <= 45
      && alarm === 1'b1 && run === 1'b0, "long outage");
    uv = 0;
    clr = 1;
    @(negedge clk);
    clr = 0;
    repeat (3) @(negedge clk);
    check(alarm === 1'b0 && cnt === 5'd0 && run === 1'b1, "clear");
    // a short outage restarts after the retry wait
    blip(60);
    check(rsts == 1 && trips == 1 && t_rst - t0 > 30 && t_rst - t0 <= 45
      && cnt === 5'd1 && run === 1'b1, "restart");
    // fifteen more restarts reach the limit, the next outage trips
    for (int k = 0; k < 15; k++) blip(50);
    check(rsts == 16 && cnt === 5'd16 && run === 1'b1, "sixteen");
    blip(50);
    check(rsts == 16 && trips == 2 && alarm === 1'b1
      && run === 1'b0, "limit trip");
    clr = 1;
    @(negedge clk);
    clr = 0;
    // match-then-stop mode restarts, stops and reports the trip
    wr(rtop_pkg::OFF_RESTART_MODE, 16'h3);
    wr(rtop_pkg::OFF_PF_ALARM_EN, 16'h0);
    u_rtop_master.idle();
    repeat (3) @(negedge clk);
    blip(50);
    check(stops == 1 && rsts == 17 && trips == 3 && cnt === 5'd1
      && alarm === 1'b0, "match stop");
    // alarm-only mode trips with the alarm disabled
    wr(rtop_pkg::OFF_RESTART_MODE, 16'h0);
    u_rtop_master.idle();
    repeat (3) @(negedge clk);
    blip(50);
    check(rsts == 17 && trips == 4 && alarm === 1'b0
      && run === 1'b0, "alarm only");
    print_verdict();
  end
endmodule
bind rtop_params rtop_params_sva u_sva (.i_clk, .i_resetn, .i_req,
  .o_ack, .o_err, .o_cfg, .o_evt, .o_alarm, .o_restart_count);
